// file: verilog/pxc_pkg.sv
// Notes on behaviour
// - Armed override lets next write change protected bits.
// - Override enable clears itself after next management write.
// - Reserved positions always read back as zero.
// - Port address captured from LED pins at reset.
// - Software reset leaves captured port address untouched.
// - Scrambler test bit forces receive side to lose lock.
// - Encoding bit picks NRZ or NRZI at 100 Mb/s, reset one; 10 Mb/s always sends NRZ.
// - Test bit clear gives standard 4B/5B translation.
// - Test bit and transmit error give test translation.
// - Test table maps each nibble to its fixed group.
// - Scrambler disable bypasses the scrambler only, not the descrambler.
// - Scrambling applies only in 100 Mb/s operation.
package pxc_pkg;

    // ------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------
    localparam logic [4:0] PXC_REG_EXT_CTRL = 5'h10;  // Extended control register number.
    localparam int         PXC_DATA_W       = 16;     // Management data width.

    // ------------------------------------------------------------
    // Field positions inside the extended control register.
    // ------------------------------------------------------------
    localparam int PXC_OW_BIT       = 15;  // Self-clearing override write enable.
    localparam int PXC_RSV_HI_MSB   = 14;  // Upper reserved group, top bit.
    localparam int PXC_RSV_HI_LSB   = 11;  // Upper reserved group, bottom bit.
    localparam int PXC_ADDR_MSB     = 10;  // Port address, top bit.
    localparam int PXC_ADDR_LSB     = 6;   // Port address, bottom bit.
    localparam int PXC_SCR_TEST_BIT = 5;   // Scrambler loss-of-lock test.
    localparam int PXC_RSV_4_BIT    = 4;   // Reserved.
    localparam int PXC_NRZI_BIT     = 3;   // NRZ (0) or NRZI (1) selection.
    localparam int PXC_INV_BIT      = 2;   // Invalid-code test translation.
    localparam int PXC_RSV_1_BIT    = 1;   // Reserved.
    localparam int PXC_SCR_DIS_BIT  = 0;   // Scrambler disable.

    // ------------------------------------------------------------
    // Values after reset.
    // ------------------------------------------------------------
    localparam logic PXC_OW_RST       = 1'h0;  // Override disarmed.
    localparam logic PXC_SCR_TEST_RST = 1'h0;  // Normal lock behaviour.
    localparam logic PXC_NRZI_RST     = 1'h1;  // NRZI coding.
    localparam logic PXC_INV_RST      = 1'h0;  // Standard translation.
    localparam logic PXC_SCR_DIS_RST  = 1'h0;  // Scrambler in use.

    // ------------------------------------------------------------
    // Transmit coding constants.
    // ------------------------------------------------------------
    localparam int         PXC_NIB_W   = 4;      // Transmit nibble width.
    localparam int         PXC_CODE_W  = 5;      // Code group width.
    localparam logic [4:0] PXC_IDLE    = 5'h1F;  // Idle code group.
    localparam logic       PXC_LINE_RST = 1'h0;  // Line level after reset.

endpackage : pxc_pkg

// file: verilog/pxc_tx_if.sv
`timescale 1ns/1ns
// Carries one transmit nibble to the translator and its code group back.
interface pxc_tx_if;
    logic [3:0] nibble;     // Nibble to translate.
    logic       test_xlat;  // High selects the invalid-code test table.
    logic [4:0] code;       // Resulting code group.

    modport drive (output nibble, output test_xlat, input code);
    modport xlat  (input nibble, input test_xlat, output code);
endinterface : pxc_tx_if

// file: verilog/pxc_code_xlat.sv
`timescale 1ns/1ns
module pxc_code_xlat
    import pxc_pkg::*;
(
    pxc_tx_if.xlat tx
);

    // ------------------------------------------------------------
    // Standard 4B/5B data translation.
    // ------------------------------------------------------------
    function automatic logic [4:0] std_group(input logic [3:0] n);
        logic [4:0] g;
        g = 5'h1E;
        case (n)
            4'h0:    g = 5'h1E;
            4'h1:    g = 5'h09;
            4'h2:    g = 5'h14;
            4'h3:    g = 5'h15;
            4'h4:    g = 5'h0A;
            4'h5:    g = 5'h0B;
            4'h6:    g = 5'h0E;
            4'h7:    g = 5'h0F;
            4'h8:    g = 5'h12;
            4'h9:    g = 5'h13;
            4'hA:    g = 5'h16;
            4'hB:    g = 5'h17;
            4'hC:    g = 5'h1A;
            4'hD:    g = 5'h1B;
            4'hE:    g = 5'h1C;
            default: g = 5'h1D;
        endcase
        return g;
    endfunction : std_group

    // ------------------------------------------------------------
    // Test translation that emits normally invalid groups.
    // ------------------------------------------------------------
    function automatic logic [4:0] test_group(input logic [3:0] n);
        logic [4:0] g;
        g = {1'h0, n};
        case (n)
            4'h8:    g = 5'h00;
            4'h9:    g = 5'h0D;
            4'hA:    g = 5'h0C;
            4'hB:    g = 5'h11;
            4'hC:    g = 5'h10;
            4'hD:    g = 5'h19;
            4'hE:    g = 5'h18;
            4'hF:    g = 5'h1F;
            default: g = {1'h0, n};  // Low nibbles pass behind a zero.
        endcase
        return g;
    endfunction : test_group

    // Picks the table; the test table only when the caller asks for it.
    always_comb
    begin
        if (tx.test_xlat)
        begin
            tx.code = test_group(tx.nibble);
        end
        else
        begin
            tx.code = std_group(tx.nibble);
        end
    end

endmodule : pxc_code_xlat

// file: verilog/pxc_ext_ctrl.sv
`timescale 1ns/1ns
module pxc_ext_ctrl
    import pxc_pkg::*;
#(
    parameter int ADDR_W = 5  // Width of the captured port address.
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              soft_rst,
    input  wire logic [4:0]        led_addr_pins,
    input  wire logic              mgmt_wr,
    input  wire logic              mgmt_rd,
    input  wire logic [4:0]        mgmt_reg,
    input  wire logic [15:0]       mgmt_wdata,
    output      logic [15:0]       mgmt_rdata,
    output      logic              mgmt_rdata_valid,
    output      logic              override_write_en,
    output      logic [ADDR_W-1:0] phy_addr,
    input  wire logic              speed_100,
    output      logic              scrambler_enable,
    output      logic              descrambler_force_unlock,
    input  wire logic              tx_en,
    input  wire logic              tx_er,
    input  wire logic [3:0]        tx_nibble,
    output      logic [4:0]        tx_code,
    output      logic [4:0]        tx_line
);

    // ------------------------------------------------------------
    // Elaboration checks.
    // ------------------------------------------------------------
    if (ADDR_W != PXC_ADDR_MSB - PXC_ADDR_LSB + 1)
    begin : g_bad_width
        $error("Port address width must match its register field.");
    end

    // ------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------
    logic [4:0]  led_meta;     // First synchroniser stage for the address pins.
    logic [4:0]  led_sync;     // Second synchroniser stage.
    logic        reg_hit;      // Access targets this register.
    logic        scr_dis;      // Scrambler disable bit.
    logic        nrzi_sel;     // NRZI selection bit.
    logic        inv_test;     // Invalid-code test bit.
    logic        line_level;   // Last level sent on the line.
    logic [15:0] rd_word;      // Register contents as read.
    logic [4:0]  nrzi_group;   // Current group after NRZI coding.

    pxc_tx_if tx_if ();

    assign reg_hit = (mgmt_reg == PXC_REG_EXT_CTRL);

    // ------------------------------------------------------------
    // Address pin synchroniser.
    // ------------------------------------------------------------

    // Pins come from off chip, so two stages stand before any use.
    always_ff @(posedge clk)
    begin
        led_meta <= led_addr_pins;
        led_sync <= led_meta;
    end

    // ------------------------------------------------------------
    // Captured port address.
    // ------------------------------------------------------------

    // Loaded only while hardware reset is held; soft reset and writes pass it by.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            phy_addr <= led_sync[ADDR_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Override write enable.
    // ------------------------------------------------------------

    // Any management write consumes the armed state; a write here may re-arm it.
    always_ff @(posedge clk)
    begin
        if (rst || soft_rst)
        begin
            override_write_en <= PXC_OW_RST;
        end
        else if (mgmt_wr && reg_hit)
        begin
            override_write_en <= mgmt_wdata[PXC_OW_BIT];
        end
        else if (mgmt_wr)
        begin
            override_write_en <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Writable control bits.
    // ------------------------------------------------------------

    // Reserved positions and the address field are not stored on writes.
    always_ff @(posedge clk)
    begin
        if (rst || soft_rst)
        begin
            descrambler_force_unlock <= PXC_SCR_TEST_RST;
            nrzi_sel                 <= PXC_NRZI_RST;
            inv_test                 <= PXC_INV_RST;
            scr_dis                  <= PXC_SCR_DIS_RST;
        end
        else if (mgmt_wr && reg_hit)
        begin
            descrambler_force_unlock <= mgmt_wdata[PXC_SCR_TEST_BIT];
            nrzi_sel                 <= mgmt_wdata[PXC_NRZI_BIT];
            inv_test                 <= mgmt_wdata[PXC_INV_BIT];
            scr_dis                  <= mgmt_wdata[PXC_SCR_DIS_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------

    // Builds the read word; every reserved position is forced to zero.
    always_comb
    begin
        rd_word                                = 16'h0000;
        rd_word[PXC_OW_BIT]                    = override_write_en;
        rd_word[PXC_ADDR_MSB:PXC_ADDR_LSB]     = phy_addr;
        rd_word[PXC_SCR_TEST_BIT]              = descrambler_force_unlock;
        rd_word[PXC_NRZI_BIT]                  = nrzi_sel;
        rd_word[PXC_INV_BIT]                   = inv_test;
        rd_word[PXC_SCR_DIS_BIT]               = scr_dis;
    end

    // Answers a read of this register one cycle later; other numbers get no answer.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mgmt_rdata       <= 16'h0000;
            mgmt_rdata_valid <= 1'h0;
        end
        else
        begin
            mgmt_rdata_valid <= mgmt_rd && reg_hit;
            if (mgmt_rd && reg_hit)
            begin
                mgmt_rdata <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Scrambler control.
    // ------------------------------------------------------------

    // Scrambling runs only at 100 Mb/s and only when not disabled.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scrambler_enable <= 1'h0;
        end
        else
        begin
            scrambler_enable <= speed_100 && !scr_dis;
        end
    end

    // ------------------------------------------------------------
    // Transmit coding.
    // ------------------------------------------------------------

    // Encodes a group MSB first, inverting the line on each one.
    function automatic logic [4:0] nrzi_code(input logic [4:0] g, input logic lvl);
        logic [4:0] o;
        logic       l;
        o = 5'h00;
        l = lvl;
        for (int i = 4; i >= 0; i--)
        begin
            l    = l ^ g[i];
            o[i] = l;
        end
        return o;
    endfunction : nrzi_code

    assign tx_if.nibble    = tx_nibble;
    assign tx_if.test_xlat = inv_test && tx_er;

    pxc_code_xlat u_xlat (
        .tx (tx_if.xlat)
    );

    assign nrzi_group = nrzi_code(tx_code, line_level);

    // Registers the group, idle while not transmitting.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_code <= PXC_IDLE;
        end
        else if (tx_en)
        begin
            tx_code <= tx_if.code;
        end
        else
        begin
            tx_code <= PXC_IDLE;
        end
    end

    // Applies NRZI only in 100 Mb/s with the bit set; otherwise plain NRZ.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_line    <= PXC_IDLE;
            line_level <= PXC_LINE_RST;
        end
        else if (speed_100 && nrzi_sel)
        begin
            tx_line    <= nrzi_group;
            line_level <= nrzi_group[0];
        end
        else
        begin
            tx_line    <= tx_code;
            line_level <= tx_code[0];
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_arm;
        mgmt_wr && reg_hit && mgmt_wdata[PXC_OW_BIT] && !soft_rst;
    endsequence

    sequence s_other_write;
        mgmt_wr && !reg_hit && !soft_rst;
    endsequence

    property p_ow_arm;
        s_arm |=> override_write_en;
    endproperty
    a_ow_arm: assert property (p_ow_arm) else $error("Override not armed.");

    property p_ow_once;
        s_arm ##1 s_other_write |=> !override_write_en;
    endproperty
    a_ow_once: assert property (p_ow_once) else $error("Override did not clear.");

    property p_rsv_zero;
        mgmt_rdata_valid |-> (mgmt_rdata[PXC_RSV_HI_MSB:PXC_RSV_HI_LSB] == 4'h0)
            && !mgmt_rdata[PXC_RSV_4_BIT] && !mgmt_rdata[PXC_RSV_1_BIT];
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved bit read as one.");

    property p_addr_read;
        mgmt_rd && reg_hit |=> mgmt_rdata_valid
            && (mgmt_rdata[PXC_ADDR_MSB:PXC_ADDR_LSB] == phy_addr);
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("Address misread.");

    property p_addr_soft;
        soft_rst |=> $stable(phy_addr);
    endproperty
    a_addr_soft: assert property (p_addr_soft) else $error("Soft reset moved address.");

    property p_addr_ro;
        mgmt_wr && reg_hit |=> $stable(phy_addr);
    endproperty
    a_addr_ro: assert property (p_addr_ro) else $error("Write moved address.");

    property p_scr_test;
        mgmt_wr && reg_hit && mgmt_wdata[PXC_SCR_TEST_BIT] && !soft_rst
            |=> descrambler_force_unlock;
    endproperty
    a_scr_test: assert property (p_scr_test) else $error("Lock test not set.");

    property p_nrz_pass;
        mgmt_wr && reg_hit && !mgmt_wdata[PXC_NRZI_BIT] && !soft_rst
            ##1 !mgmt_wr |=> tx_line == $past(tx_code);
    endproperty
    a_nrz_pass: assert property (p_nrz_pass) else $error("NRZ output altered.");

    property p_std_zero;
        tx_en && !inv_test && tx_nibble == 4'h0 |=> tx_code == 5'h1E;
    endproperty
    a_std_zero: assert property (p_std_zero) else $error("Standard group wrong.");

    property p_test_xlat;
        tx_en && tx_er && inv_test && tx_nibble == 4'h9 |=> tx_code == 5'h0D;
    endproperty
    a_test_xlat: assert property (p_test_xlat) else $error("Test group wrong.");

    property p_test_low;
        tx_en && tx_er && inv_test && !tx_nibble[3] |=> tx_code == {1'h0, $past(tx_nibble)};
    endproperty
    a_test_low: assert property (p_test_low) else $error("Low test group wrong.");

    property p_scr_10m;
        !speed_100 |=> !scrambler_enable;
    endproperty
    a_scr_10m: assert property (p_scr_10m) else $error("Scrambler on at 10 Mb/s.");

    property p_scr_dis;
        scr_dis |=> !scrambler_enable;
    endproperty
    a_scr_dis: assert property (p_scr_dis) else $error("Scrambler not bypassed.");

endmodule : pxc_ext_ctrl

// file: dv/pxc_mgmt_model.sv
`timescale 1ns/1ns
// --------------------
// Management station model.
// --------------------
module pxc_mgmt_model
    import pxc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] mgmt_rdata,
    input  wire logic        mgmt_rdata_valid,
    output      logic        mgmt_wr,
    output      logic        mgmt_rd,
    output      logic [4:0]  mgmt_reg,
    output      logic [15:0] mgmt_wdata
);
    // The bus idles from time zero.
    initial
    begin
        mgmt_wr    = 1'b0;
        mgmt_rd    = 1'b0;
        mgmt_reg   = 5'h00;
        mgmt_wdata = 16'h0000;
    end

    // One write, entered just after an edge; reserved bits go out as zero.
    task automatic write(input logic [4:0] num, input logic [15:0] data);
        mgmt_reg   = num;
        mgmt_wdata = (num == PXC_REG_EXT_CTRL) ? (data & 16'h87ED) : data;
        mgmt_wr    = 1'b1;
        @(posedge clk);
        #1;
        mgmt_wr    = 1'b0;
        mgmt_wdata = ~mgmt_wdata;  // Stale data is not left on the bus.
        @(posedge clk);  // One idle cycle, so a following call never re-drives in this step.
        #1;
    endtask : write

    // One read; the answer is taken just after the edge that samples the request.
    task automatic read(input logic [4:0] num, output logic [15:0] data, output logic ok);
        mgmt_reg = num;
        mgmt_rd  = 1'b1;
        @(posedge clk);
        #1;
        mgmt_rd  = 1'b0;
        mgmt_reg = ~num;
        ok       = mgmt_rdata_valid;
        data     = mgmt_rdata;
        @(posedge clk);  // One idle cycle, so a following call never re-drives in this step.
        #1;
    endtask : read

    // Arms the override, then writes another register on the very next edge.
    task automatic arm_write(input logic [15:0] ctrl, input logic [4:0] num,
                             input logic [15:0] data);
        mgmt_reg   = PXC_REG_EXT_CTRL;
        mgmt_wdata = (ctrl | 16'h8000) & 16'h87ED;
        mgmt_wr    = 1'b1;
        @(posedge clk);
        #1;
        mgmt_reg   = num;  // The strobe stays high across both writes.
        mgmt_wdata = data;
        @(posedge clk);
        #1;
        mgmt_wr    = 1'b0;
        mgmt_wdata = ~mgmt_wdata;
        @(posedge clk);
        #1;
    endtask : arm_write

    // Arms the override again before each protected write.
    task automatic arm(input logic [15:0] ctrl);
        write(PXC_REG_EXT_CTRL, ctrl | 16'h8000);
    endtask : arm
endmodule : pxc_mgmt_model

// file: dv/tb.sv
`timescale 1ns/1ns
module tb
    import pxc_pkg::*;
;
    // --------------------
    // Signals and tables.
    // --------------------
    logic        clk, rst, soft_rst, speed_100, tx_en, tx_er;  // Bench controls.
    logic [4:0]  led_pins;                                  // Address strap pins.
    logic [3:0]  tx_nibble;                                 // Transmit nibble.
    logic        mgmt_wr, mgmt_rd, valid, ow_en, scr_en, unlock;  // Flags.
    logic [4:0]  mgmt_reg, phy_addr, tx_code, tx_line;      // Numbers and groups.
    logic [15:0] mgmt_wdata, mgmt_rdata, rd_word;           // Register words.
    logic        rd_ok;                                     // Read was answered.
    int          fails, n_tests;                            // Result counters.
    int          cycles = 0;                                // Hang guard.

    // Test translation and standard 4B/5B groups, by nibble.
    localparam logic [4:0] TEST_TBL [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
        5'h06, 5'h07, 5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
    localparam logic [4:0] STD_TBL [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    // Clock of 10 ns.
    always #5 clk = ~clk;

    pxc_ext_ctrl #(.ADDR_W(5)) i_dut (.clk(clk), .rst(rst), .soft_rst(soft_rst),
        .led_addr_pins(led_pins), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_reg(mgmt_reg), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_rdata_valid(valid), .override_write_en(ow_en), .phy_addr(phy_addr),
        .speed_100(speed_100), .scrambler_enable(scr_en),
        .descrambler_force_unlock(unlock), .tx_en(tx_en), .tx_er(tx_er),
        .tx_nibble(tx_nibble), .tx_code(tx_code), .tx_line(tx_line));

    pxc_mgmt_model i_mgmt (.clk(clk), .mgmt_rdata(mgmt_rdata), .mgmt_rdata_valid(valid),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_reg(mgmt_reg),
        .mgmt_wdata(mgmt_wdata));

    // --------------------
    // Helpers.
    // --------------------
    // Moves to just after the next rising edge.
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    // Compares a register word.
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    // Compares a five-bit group.
    task automatic chk_code(input string what, input logic [4:0] exp, input logic [4:0] got);
        chk_word(what, {11'h000, exp}, {11'h000, got});
    endtask : chk_code

    // Compares a single flag.
    task automatic chk_flag(input string what, input logic exp, input logic got);
        chk_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask : chk_flag

    // Builds the control word from {test, nrzi, invalid, disable}.
    function automatic logic [15:0] ctrl_word(input logic ow, input logic [4:0] a,
                                              input logic [3:0] b);
        return {ow, 4'h0, a, b[3], 1'b0, b[2], b[1], 1'b0, b[0]};
    endfunction : ctrl_word

    // Reads the extended control register.
    task automatic read_ext;
        i_mgmt.read(PXC_REG_EXT_CTRL, rd_word, rd_ok);
        chk_flag("read answered", 1'b1, rd_ok);
    endtask : read_ext

    // Sends all nibbles back to back; checks code groups and line groups.
    task automatic run_nibbles(input logic [4:0] tbl [16], input logic nrzi);
        logic [4:0] e;
        logic       lvl;
        e     = 5'h00;
        lvl   = 1'b0;
        tx_en = 1'b1;
        for (int i = 0; i < 17; i++)
        begin
            tx_nibble = 4'(i);
            step;
            if (i < 16)
                chk_code("code group", tbl[i], tx_code);
            if (i == 0)
                lvl = tx_line[0];  // Seeds the level left by the group ahead of the data.
            else
            begin
                e = tbl[i-1];
                // The line level carries over from the last bit of the prior group.
                for (int b = 4; b >= 0 && nrzi; b--)
                begin
                    lvl  = lvl ^ e[b];
                    e[b] = lvl;
                end
                chk_code("line group", e, tx_line);
                lvl = e[0];
            end
        end
        tx_en = 1'b0;
    endtask : run_nibbles

    // --------------------
    // Scenarios.
    // --------------------
    // Defaults after hardware reset, and a read of a foreign register.
    task automatic t_reset_vals;
        chk_flag("override idle", 1'b0, ow_en);
        chk_code("address", 5'h15, phy_addr);
        read_ext;
        chk_word("reset word", ctrl_word(1'b0, 5'h15, 4'h4), rd_word);
        i_mgmt.read(5'h11, rd_word, rd_ok);
        chk_flag("foreign read", 1'b0, rd_ok);
    endtask : t_reset_vals

    // Control bits, scrambler gating and the read-only address.
    task automatic t_controls;
        i_mgmt.write(PXC_REG_EXT_CTRL, ctrl_word(1'b0, 5'h0A, 4'hB));
        step;
        chk_flag("unlock set", 1'b1, unlock);
        chk_flag("scrambler at 10M", 1'b0, scr_en);
        read_ext;
        chk_word("control word", ctrl_word(1'b0, 5'h15, 4'hB), rd_word);
        speed_100 = 1'b1;
        step;
        step;
        chk_flag("scrambler bypassed", 1'b0, scr_en);
        i_mgmt.write(PXC_REG_EXT_CTRL, ctrl_word(1'b0, 5'h15, 4'h4));
        step;
        chk_flag("scrambler on", 1'b1, scr_en);
        chk_flag("unlock clear", 1'b0, unlock);
        speed_100 = 1'b0;
        step;
        step;
        chk_flag("scrambler off at 10M", 1'b0, scr_en);
    endtask : t_controls

    // Override arms, survives a read and clears after one write.
    task automatic t_override;
        i_mgmt.arm(16'h0008);
        chk_flag("override armed", 1'b1, ow_en);
        read_ext;
        chk_word("armed word", ctrl_word(1'b1, 5'h15, 4'h4), rd_word);
        chk_flag("read keeps override", 1'b1, ow_en);
        i_mgmt.write(5'h04, 16'h1234);
        chk_flag("override spent", 1'b0, ow_en);
        i_mgmt.arm_write(16'h0008, 5'h04, 16'h4321);
        chk_flag("override spent by next write", 1'b0, ow_en);
        step;
        i_mgmt.arm(16'h0008);
        step;
        i_mgmt.write(PXC_REG_EXT_CTRL, 16'h0008);
        chk_flag("override cleared", 1'b0, ow_en);
    endtask : t_override

    // Test translation with transmit error, NRZ line at 100 Mb/s.
    task automatic t_tx_test;
        speed_100 = 1'b1;
        tx_er = 1'b1;
        i_mgmt.write(PXC_REG_EXT_CTRL, ctrl_word(1'b0, 5'h15, 4'h2));
        run_nibbles(TEST_TBL, 1'b0);
    endtask : t_tx_test

    // Standard groups when either condition of the test table is missing.
    task automatic t_tx_std;
        tx_er = 1'b0;
        i_mgmt.write(PXC_REG_EXT_CTRL, ctrl_word(1'b0, 5'h15, 4'h6));
        run_nibbles(STD_TBL, 1'b1);
        tx_er = 1'b1;
        speed_100 = 1'b0;
        i_mgmt.write(PXC_REG_EXT_CTRL, ctrl_word(1'b0, 5'h15, 4'h4));
        run_nibbles(STD_TBL, 1'b0);
        step;
        chk_code("idle group", PXC_IDLE, tx_code);
    endtask : t_tx_std

    // Soft reset keeps the address; a hardware reset captures new pins.
    task automatic t_soft_rst;
        led_pins = 5'h0A;
        i_mgmt.write(PXC_REG_EXT_CTRL, ctrl_word(1'b0, 5'h00, 4'hB));
        soft_rst = 1'b1;
        step;
        soft_rst = 1'b0;
        read_ext;
        chk_word("after soft reset", ctrl_word(1'b0, 5'h15, 4'h4), rd_word);
        rst = 1'b1;
        repeat (4) step;
        rst = 1'b0;
        read_ext;
        chk_word("after hard reset", ctrl_word(1'b0, 5'h0A, 4'h4), rd_word);
    endtask : t_soft_rst

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // Cuts a hang short after far more cycles than the tests need.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            print_verdict;
        end
    end

    // Main sequence.
    initial
    begin
        clk       = 1'b0;
        rst       = 1'b1;
        soft_rst  = 1'b0;
        speed_100 = 1'b0;
        tx_en     = 1'b0;
        tx_er     = 1'b0;
        tx_nibble = 4'h0;
        led_pins  = 5'h15;
        fails     = 0;
        n_tests   = 0;
        repeat (4) step;
        rst = 1'b0;
        t_reset_vals;
        t_controls;
        t_override;
        t_tx_test;
        t_tx_std;
        t_soft_rst;
        print_verdict;
    end
endmodule : tb
